// ### verilog/lbss_steer.sv
// Shadow area steering: three map registers and the per-cycle DRAM or south link decision
`timescale 1ns/1ps
`include "lbss_defs.svh"

// Notes on behaviour
// [R1] Offset 94h steers 0D8000h-0DFFFFh halves
// [R2] Offset 95h steers 0E0000h-0E7FFFh halves
// [R3] Offset 96h steers 0E8000h-0EFFFFh halves
// [R4] Field picks destination of reads and writes
// [R5] 00: reads and writes to south link
// [R6] 01: reads DRAM, writes south link
// [R7] 10: writes DRAM, reads south link
// [R8] 11: reads and writes to DRAM
// [R9] Reset zero; reserved bits zero, unwritable
module lbss_steer (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // Configuration access
   input  wire logic                 cfg_wr,
   input  wire logic                 cfg_rd,
   input  wire logic [7:0]           cfg_addr,
   input  wire lbss_pkg::lbss_cfg_t  cfg_wdata,
   output lbss_pkg::lbss_cfg_t       cfg_rdata,
   output logic                      cfg_rvalid,
   // Host cycle in
   input  wire logic                 cyc_valid,
   input  wire logic                 cyc_write,
   input  wire lbss_pkg::lbss_addr_t cyc_addr,
   // Routed cycle out
   output logic                      route_valid,
   output logic                      route_write,
   output lbss_pkg::lbss_addr_t      route_addr,
   output logic                      route_dram,
   output logic                      route_south,
   output logic                      route_pass
);

   // One-hot select of the map register named by a configuration offset
   function automatic logic [`LBSS_NUM_MAPS-1:0] map_select(input logic [7:0] offset);
      logic [`LBSS_NUM_MAPS-1:0] sel;
      sel = '0;
      if (offset == `LBSS_OFF_MAP_D8)
         sel = 3'h1;
      else if (offset == `LBSS_OFF_MAP_E0)
         sel = 3'h2;
      else if (offset == `LBSS_OFF_MAP_E8)
         sel = 3'h4;
      return sel;
   endfunction : map_select

   lbss_pkg::lbss_cfg_t        map [0:`LBSS_NUM_MAPS-1];
   logic [`LBSS_NUM_MAPS-1:0]  wr_sel;
   logic [`LBSS_NUM_MAPS-1:0]  rd_sel;
   lbss_pkg::lbss_cfg_t        next_rdata;
   lbss_pkg::lbss_cfg_t        shadow_map_d8_df;
   lbss_pkg::lbss_cfg_t        shadow_map_e0_e7;
   lbss_pkg::lbss_cfg_t        shadow_map_e8_ef;

   assign wr_sel = cfg_wr ? map_select(cfg_addr) : '0;
   assign rd_sel = map_select(cfg_addr);

   // Map registers; only the two attribute fields ever store a one
   for (genvar i = 0; i < `LBSS_NUM_MAPS; i++)
   begin : g_map
      always_ff @(posedge clk or negedge rstn)
      begin
         if (!rstn)
            map[i] <= `LBSS_MAP_RESET;                 // R9
         else if (wr_sel[i])
            map[i] <= cfg_wdata & `LBSS_MAP_WMASK;     // R9
      end
   end

   // Named views of the three registers
   assign shadow_map_d8_df = map[0];                   // R1
   assign shadow_map_e0_e7 = map[1];                   // R2
   assign shadow_map_e8_ef = map[2];                   // R3

   // Read mux; an unmapped offset reads as zero rather than floating
   always_comb
   begin
      next_rdata = '0;
      for (int i = 0; i < `LBSS_NUM_MAPS; i++)
      begin
         if (rd_sel[i])
            next_rdata = next_rdata | map[i];
      end
   end

   // Read data registered so the port comes from a flip-flop
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_rdata  <= '0;
         cfg_rvalid <= 1'b0;
      end
      else
      begin
         cfg_rvalid <= cfg_rd;
         cfg_rdata  <= cfg_rd ? next_rdata : '0;
      end
   end

   // Region decode: address bits 19:14 number the 16 KB half
   logic [5:0]            half_num;
   logic                  cyc_hit;
   logic [2:0]            half_idx;
   lbss_pkg::lbss_cfg_t   half_map;
   lbss_pkg::lbss_attr_t  cyc_attr;
   logic                  dec_dram;
   logic                  dec_south;

   assign half_num = cyc_addr[19:14];
   assign cyc_hit  = (cyc_addr[31:20] == `LBSS_HIGH_ZERO) &&
                     (half_num >= `LBSS_HALF_FIRST) && (half_num <= `LBSS_HALF_LAST);
   assign half_idx = cyc_hit ? 3'(half_num - `LBSS_HALF_FIRST) : 3'h0;
   // Even half number is the lower half of its register, odd the upper
   assign half_map = map[half_idx[2:1]];
   assign cyc_attr = half_idx[0] ? half_map[`LBSS_HI_LSB +: 2] : half_map[`LBSS_LO_LSB +: 2];  // R4

   lbss_attr_decode u_decode (
      .attr     (cyc_attr),
      .is_write (cyc_write),
      .to_dram  (dec_dram),
      .to_south (dec_south)
   );

   // Routed cycle: one cycle of latency; cycles outside the window pass untouched
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         route_valid <= 1'b0;
         route_write <= 1'b0;
         route_addr  <= '0;
         route_dram  <= 1'b0;
         route_south <= 1'b0;
         route_pass  <= 1'b0;
      end
      else
      begin
         route_valid <= cyc_valid;
         route_write <= cyc_valid && cyc_write;
         route_addr  <= cyc_valid ? cyc_addr : '0;
         route_dram  <= cyc_valid && cyc_hit && dec_dram;     // R4
         route_south <= cyc_valid && cyc_hit && dec_south;    // R4
         route_pass  <= cyc_valid && !cyc_hit;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_hit_cycle(logic [1:0] code, logic wr);
      cyc_valid && cyc_hit && (cyc_attr == code) && (cyc_write == wr);
   endsequence

   sequence s_to_dram;
      route_valid && route_dram && !route_south && !route_pass;
   endsequence

   sequence s_to_south;
      route_valid && route_south && !route_dram && !route_pass;
   endsequence

   a_d8_write_map: assert property (cfg_wr && cfg_addr == `LBSS_OFF_MAP_D8 |=>   // R1
      shadow_map_d8_df == ($past(cfg_wdata) & `LBSS_MAP_WMASK))
      else $error("d8 map register did not take the write");

   a_d8_low_half: assert property (cyc_valid && cyc_addr[31:14] == 18'h0_0036 |=>   // R1
      route_dram == $past(cyc_write ? shadow_map_d8_df[1:0] inside {2'h2, 2'h3}
                                    : shadow_map_d8_df[1:0] inside {2'h1, 2'h3}))
      else $error("d8 lower half routed against its field");

   a_e0_write_map: assert property (cfg_wr && cfg_addr == `LBSS_OFF_MAP_E0 |=>   // R2
      shadow_map_e0_e7 == ($past(cfg_wdata) & `LBSS_MAP_WMASK))
      else $error("e0 map register did not take the write");

   a_e8_upper_half: assert property (cyc_valid && cyc_addr[31:14] == 18'h0_003B &&   // R3
      shadow_map_e8_ef[5:4] == `LBSS_ATTR_OFF |=> s_to_south)
      else $error("ec upper half with field 00 not sent south");

   a_window_hit: assert property (cyc_valid |=> route_pass == !$past(cyc_hit) &&   // R4
      route_addr == $past(cyc_addr))
      else $error("window hit or address not carried");

   a_off_both: assert property (s_hit_cycle(`LBSS_ATTR_OFF, 1'b0) or   // R5
      s_hit_cycle(`LBSS_ATTR_OFF, 1'b1) |=> s_to_south)
      else $error("field 00 cycle reached dram");

   a_ro_read: assert property (s_hit_cycle(`LBSS_ATTR_RO, 1'b0) |=> s_to_dram)   // R6
      else $error("field 01 read not from dram");

   a_ro_write: assert property (s_hit_cycle(`LBSS_ATTR_RO, 1'b1) |=> s_to_south)   // R6
      else $error("field 01 write not sent south");

   a_wo_write: assert property (s_hit_cycle(`LBSS_ATTR_WO, 1'b1) |=> s_to_dram)   // R7
      else $error("field 10 write not to dram");

   a_wo_read: assert property (s_hit_cycle(`LBSS_ATTR_WO, 1'b0) |=> s_to_south)   // R7
      else $error("field 10 read not sent south");

   a_rw_both: assert property (s_hit_cycle(`LBSS_ATTR_RW, 1'b0) or   // R8
      s_hit_cycle(`LBSS_ATTR_RW, 1'b1) |=> s_to_dram)
      else $error("field 11 cycle not to dram");

   a_reserved_read: assert property (cfg_rd |=> cfg_rvalid &&   // R9
      (cfg_rdata & ~`LBSS_MAP_WMASK) == 8'h00 && cfg_rdata == $past(next_rdata))
      else $error("reserved bits read nonzero or read data wrong");

   a_map_hold: assert property (!cfg_wr |=>   // R9
      $stable(shadow_map_e8_ef) && $stable(shadow_map_d8_df) && $stable(shadow_map_e0_e7))
      else $error("map register changed without a write");

   // A stray offset must not alias onto any map register
   a_stray_write: assert property (cfg_wr && map_select(cfg_addr) == 3'h0 |=>   // R9
      $stable(shadow_map_d8_df) && $stable(shadow_map_e0_e7) && $stable(shadow_map_e8_ef))
      else $error("write to an unmapped offset changed a map register");

   a_e0_upper_half: assert property (cyc_valid && cyc_addr[31:14] == 18'h0_0039 &&   // R2
      shadow_map_e0_e7[5:4] == `LBSS_ATTR_RW |=> s_to_dram)
      else $error("e4 upper half with field 11 not sent to dram");

   a_e8_write_map: assert property (cfg_wr && cfg_addr == `LBSS_OFF_MAP_E8 |=>   // R3
      shadow_map_e8_ef == ($past(cfg_wdata) & `LBSS_MAP_WMASK))
      else $error("e8 map register did not take the write");

   a_e8_lower_half: assert property (cyc_valid && cyc_addr[31:14] == 18'h0_003A &&   // R3
      shadow_map_e8_ef[1:0] == `LBSS_ATTR_RO |=> route_dram == !$past(cyc_write))
      else $error("e8 lower half with field 01 misrouted");

   // Downstream sinks trust that a routed cycle lands in exactly one place
   a_one_dest: assert property (route_valid |->   // R4
      $onehot({route_dram, route_south, route_pass}))
      else $error("routed cycle has not exactly one destination");

   a_idle_quiet: assert property (!route_valid |->   // R4
      !route_dram && !route_south && !route_pass && !route_write)
      else $error("destination raised without a routed cycle");

endmodule : lbss_steer

// ### verilog/lbss_defs.svh
// Offsets, field positions, reset values and encodings of the shadow steering block
`ifndef LBSS_DEFS_SVH
`define LBSS_DEFS_SVH

// Configuration offsets of the three map registers
`define LBSS_OFF_MAP_D8    8'h94
`define LBSS_OFF_MAP_E0    8'h95
`define LBSS_OFF_MAP_E8    8'h96
`define LBSS_NUM_MAPS      3

// Reset value and writable bits (fields 5:4 and 1:0)
`define LBSS_MAP_RESET     8'h00
`define LBSS_MAP_WMASK     8'h33
`define LBSS_LO_LSB        0
`define LBSS_HI_LSB        4

// Attribute encodings
`define LBSS_ATTR_OFF      2'h0
`define LBSS_ATTR_RO       2'h1
`define LBSS_ATTR_WO       2'h2
`define LBSS_ATTR_RW       2'h3

// 16 KB half numbers (address bits 19:14) covered: 0D8000h up to 0EFFFFh
`define LBSS_HALF_FIRST    6'h36
`define LBSS_HALF_LAST     6'h3B
`define LBSS_HIGH_ZERO     12'h000

`endif

// ### verilog/lbss_pkg.sv
// Types shared by the shadow steering block
package lbss_pkg;
   typedef logic [1:0]  lbss_attr_t;
   typedef logic [7:0]  lbss_cfg_t;
   typedef logic [31:0] lbss_addr_t;
endpackage : lbss_pkg

// ### verilog/lbss_attr_decode.sv
// Attribute decoder: turns a two-bit field and the cycle direction into a destination
`timescale 1ns/1ps
`include "lbss_defs.svh"

module lbss_attr_decode (
   // Field and cycle
   input  wire lbss_pkg::lbss_attr_t attr,
   input  wire logic                 is_write,
   // Destination
   output logic                      to_dram,
   output logic                      to_south
);

   // Exactly one destination for every field value and direction
   always_comb
   begin
      case (attr)
         `LBSS_ATTR_OFF: to_dram = 1'b0;              // R5
         `LBSS_ATTR_RO:  to_dram = !is_write;         // R6
         `LBSS_ATTR_WO:  to_dram = is_write;          // R7
         default:        to_dram = 1'b1;              // R8
      endcase
      to_south = !to_dram;
   end

endmodule : lbss_attr_decode

// ### dv/lbss_sink.sv
// Far-side model: DRAM and south link sinks that count the cycles steered to each
`timescale 1ns/1ps

module lbss_sink (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Routed cycle
   input  wire logic route_valid,
   input  wire logic route_dram,
   input  wire logic route_south,
   // Tallies
   output int        n_dram,
   output int        n_south
);
   // Both sinks accept every cycle at once; the block offers no back-pressure
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         n_dram  <= 0;
         n_south <= 0;
      end
      else if (route_valid)
      begin
         n_dram  <= n_dram + int'(route_dram);
         n_south <= n_south + int'(route_south);
      end
   end
endmodule : lbss_sink

// ### dv/tb_top.sv
// Self-checking bench for the shadow steering block
`timescale 1ns/1ps
`include "lbss_defs.svh"
`define CHK(nm, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         $display("[ERR] %s expected %h seen %h", nm, exp, got); \
         err_total++; \
      end \
   end

module tb_top;
   logic                 clk = 1'b0;
   logic                 rstn = 1'b0;
   logic                 cfg_wr = 1'b0;
   logic                 cfg_rd = 1'b0;
   logic [7:0]           cfg_addr = 8'h00;
   lbss_pkg::lbss_cfg_t  cfg_wdata = 8'h00;
   lbss_pkg::lbss_cfg_t  cfg_rdata;
   logic                 cfg_rvalid;
   logic                 cyc_valid = 1'b0;
   logic                 cyc_write = 1'b0;
   lbss_pkg::lbss_addr_t cyc_addr = 32'h0000_0000;
   logic                 route_valid, route_write, route_dram, route_south, route_pass;
   lbss_pkg::lbss_addr_t route_addr;
   int                   n_dram, n_south, exp_dram, exp_south, err_total, samples_checked;
   logic [7:0]           offs [3] = '{`LBSS_OFF_MAP_D8, `LBSS_OFF_MAP_E0, `LBSS_OFF_MAP_E8};
   logic [7:0]           w;
   logic [1:0]           f;
   logic                 dr;

   lbss_steer i_dut (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cyc_valid(cyc_valid),
      .cyc_write(cyc_write), .cyc_addr(cyc_addr), .route_valid(route_valid), .route_write(route_write),
      .route_addr(route_addr), .route_dram(route_dram), .route_south(route_south), .route_pass(route_pass));
   lbss_sink i_sink (.clk(clk), .rstn(rstn), .route_valid(route_valid), .route_dram(route_dram),
      .route_south(route_south), .n_dram(n_dram), .n_south(n_south));

   // 100 MHz clock
   initial
   begin
      forever #5 clk = ~clk;
   end

   // Strobe tasks leave an idle cycle so no signal is set twice in one step
   task automatic cfg_write(input logic [7:0] addr, input lbss_pkg::lbss_cfg_t data);
      cfg_wr    = 1'b1;
      cfg_addr  = addr;
      cfg_wdata = data;
      @(negedge clk);
      cfg_wr = 1'b0;
      @(negedge clk);
   endtask : cfg_write

   task automatic cfg_read(input logic [7:0] addr, input lbss_pkg::lbss_cfg_t exp);
      cfg_rd   = 1'b1;
      cfg_addr = addr;
      @(negedge clk);
      cfg_rd = 1'b0;
      `CHK("cfg_rvalid", 1'b1, cfg_rvalid)
      `CHK("cfg_rdata", exp, cfg_rdata)
      @(negedge clk);
      `CHK("cfg_rvalid_drop", 1'b0, cfg_rvalid)
      `CHK("cfg_rdata_drop", 8'h00, cfg_rdata)
   endtask : cfg_read

   // Host cycles are held back to back; the caller drops cyc_valid after the burst
   task automatic host_cycle(input logic wr, input lbss_pkg::lbss_addr_t addr, input logic [2:0] exp);
      cyc_valid = 1'b1;
      cyc_write = wr;
      cyc_addr  = addr;
      @(negedge clk);
      `CHK("route_valid", 1'b1, route_valid)
      `CHK("route_write", wr, route_write)
      `CHK("route_addr", addr, route_addr)
      `CHK("dram_south_pass", exp, {route_dram, route_south, route_pass})
      exp_dram  += int'(exp[2]);
      exp_south += int'(exp[1]);
   endtask : host_cycle

   task automatic summarize();
      $display("Checks made %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   // Main sequence
   initial
   begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      cfg_write(8'h97, 8'hFF);
      foreach (offs[i]) cfg_read(offs[i], 8'h00);
      cfg_read(8'h97, 8'h00);
      for (int a = 0; a < 4; a++)
      begin
         // Lower and upper fields differ so a swapped half shows up
         w = 8'hCC | {2'b00, 2'(a ^ 3), 2'b00, 2'(a)};
         foreach (offs[i]) cfg_write(offs[i], w);
         foreach (offs[i]) cfg_read(offs[i], w & 8'h33);
         for (int h = 0; h < 6; h++)
         begin
            for (int d = 0; d < 2; d++)
            begin
               f  = h[0] ? 2'(a ^ 3) : 2'(a);
               dr = d[0] ? f[1] : f[0];
               host_cycle(d[0], 32'h000D_8000 + (32'(h) << 14) + (a[0] ? 32'h0000_3FFF : 32'h0000_0000),
                  {dr, !dr, 1'b0});
            end
         end
         host_cycle(1'b0, 32'h000D_7FFF, 3'b001);
         host_cycle(1'b1, 32'h000F_0000, 3'b001);
         host_cycle(1'b0, 32'h100D_8000, 3'b001);
         cyc_valid = 1'b0;
         @(negedge clk);
         `CHK("route_idle", 1'b0, route_valid)
      end
      `CHK("dram_count", exp_dram, n_dram)
      `CHK("south_count", exp_south, n_south)
      summarize();
   end

   // Watchdog against a hang
   initial
   begin
      repeat (5000) @(posedge clk);
      err_total++;
      summarize();
   end
endmodule : tb_top
